// ===== common/rwd_pkg.sv
// Constants and state types for the remote wake event detector.
package rwd_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADR_PMC = 8'h00;
  localparam logic [7:0] ADR_MWC = 8'h04;
  localparam logic [7:0] ADR_LPC = 8'h08;
  localparam logic [7:0] ADR_HPC = 8'h0C;
  localparam logic [7:0] ADR_PWK = 8'h10;
  localparam logic [7:0] ADR_IST = 8'h14;

  // power_mgmt_control fields.
  localparam int PMC_WAKEUP_STATUS_BITS_ED = 0;
  localparam int PMC_WAKEUP_STATUS_BITS_LAN = 1;
  localparam int PMC_ENERGY_WAKE_EN = 2;
  localparam int PMC_LAN_EN = 3;
  localparam int PMC_MODE_LSB = 4;
  localparam int PMC_READY = 6;
  localparam int PMC_STATE_LSB = 8;

  // mac_wake_ctrl_status fields.
  localparam int MWC_UNI_EN = 0;
  localparam int MWC_MAG_EN = 1;
  localparam int MWC_FRM_EN = 2;
  localparam int MWC_FRM_SEEN = 4;
  localparam int MWC_MAG_SEEN = 5;

  // Pin configuration fields.
  localparam int LPC_DIR_LSB = 8;
  localparam int HPC_DIR_LSB = 8;
  localparam int PWK_POL_LSB = 8;

  // Suspend mode encodings.
  localparam logic [1:0] MODE_A = 2'h0;
  localparam logic [1:0] MODE_B = 2'h1;
  localparam logic [1:0] MODE_RST = 2'h2;

  // Pin counts.
  localparam int NUM_PINS = 8;
  localparam int NUM_LOW = 3;
  localparam int NUM_HIGH = 5;
  localparam int SYNC_W = 9;

  typedef enum logic [1:0] {
    RWD_NORMAL,
    RWD_SUSP_A,
    RWD_SUSP_B,
    RWD_SUSP_C
  } rwd_pstate_t;

  typedef struct packed {
    rwd_pstate_t pstate;
    logic [1:0] wakeup_status_bits;
    logic energy_wake_en;
    logic lan_en;
    logic [1:0] mode;
    logic uni_en;
    logic mag_en;
    logic frm_en;
    logic frm_seen;
    logic mag_seen;
    logic [5:0] func;
    logic [2:0] low_dir;
    logic [4:0] high_en;
    logic [4:0] high_dir;
    logic [7:0] pin_wen;
    logic [7:0] pin_pol;
    logic [7:0] pin_sts;
    logic ack;
    logic [31:0] rdata;
    logic wake;
  } rwd_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } rwd_sync_t;

endpackage

// ===== rtl/rwd_sync.sv
// Two-stage synchroniser for the pin and PHY interrupt inputs.
`timescale 1ns/10ps
module rwd_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, clean levels out
  input wire logic [rwd_pkg::SYNC_W-1:0] async_i,
  output logic [rwd_pkg::SYNC_W-1:0] sync_o
);
  import rwd_pkg::*;

  rwd_sync_t q;
  rwd_sync_t d;

  always_comb begin
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule

// ===== rtl/rwd_pin_wake.sv
// Per-pin wake qualification: input mode, polarity match and enable.
`timescale 1ns/10ps
module rwd_pin_wake (
  // Synchronised pin levels
  input wire logic [rwd_pkg::NUM_PINS-1:0] pin_i,
  // Pin configuration
  input wire logic [5:0] func_i,
  input wire logic [rwd_pkg::NUM_LOW-1:0] low_dir_i,
  input wire logic [rwd_pkg::NUM_HIGH-1:0] high_en_i,
  input wire logic [rwd_pkg::NUM_HIGH-1:0] high_dir_i,
  input wire logic [rwd_pkg::NUM_PINS-1:0] pol_i,
  input wire logic [rwd_pkg::NUM_PINS-1:0] wen_i,
  // Qualified wake hits
  output logic [rwd_pkg::NUM_PINS-1:0] hit_o
);
  import rwd_pkg::*;

  logic [NUM_PINS-1:0] is_in;

  genvar i;
  generate
    // RQ9: low pins input mode.
    for (i = 0; i < NUM_LOW; i++) begin : g_low
      assign is_in[i] = (func_i[2*i+1 -: 2] == 2'h0) && !low_dir_i[i];
    end
    // RQ10: high pins input mode.
    for (i = 0; i < NUM_HIGH; i++) begin : g_high
      assign is_in[NUM_LOW+i] = !high_en_i[i] && !high_dir_i[i];
    end
    // RQ11: polarity match gated.
    for (i = 0; i < NUM_PINS; i++) begin : g_hit
      assign hit_o[i] = is_in[i] && wen_i[i] && (pin_i[i] == pol_i[i]);
    end
  endgenerate
endmodule

// ===== rtl/rwd_top.sv
// Remote wake event detector with its Wishbone register slave.
`timescale 1ns/10ps
// Contract
// RQ1: Gate three MAC detections, merge into composite.
// RQ2: Raise wake interrupt from enabled LAN or energy.
// RQ3: Two wakeup status bits, bit 1 LAN.
// RQ4: Separate wake frame and magic frame status.
// RQ5: LAN wakes only in suspend state A.
// RQ6: Energy wakes only in suspend state B.
// RQ7: Wake interrupt asserts remote wake output.
// RQ8: Pin wake accepted in any suspend state.
// RQ9: Host clears function and direction, pins 0-2.
// RQ10: Host clears enable and direction, pins 3-7.
// RQ11: Per-pin polarity and enable select wake.
// RQ12: Per-pin event status bits seven to zero.
// RQ13: Host halts MAC before arming and suspending.
// RQ14: Pin wake returns normal, signals remote wake.
// RQ15: Host clears LAN status before enabling.
// RQ16: LAN status clear ignored while event present.
// RQ17: Host picks mode 00b then suspends.
// RQ18: Wake frame in suspend returns normal, wakes.
// RQ19: Host enables MAC and PHY detection first.
// RQ20: Mode 01b suspends into state B.
// RQ21: Mode 10b/11b suspends deepest; pins/resume only.
// RQ22: Energy status bit 0 held while PHY asserted.
// RQ23: Host clears pin status before suspending.
// RQ24: Synchronise pins and PHY interrupt first.
// RQ25: Set status with enable is level request.
module rwd_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // MAC detections, one-cycle pulses
  input wire logic unicast_hit_i,
  input wire logic magic_hit_i,
  input wire logic frame_hit_i,
  // PHY interrupt and wake pins, asynchronous levels
  input wire logic phy_irq_i,
  input wire logic [rwd_pkg::NUM_PINS-1:0] pin_i,
  // USB side
  input wire logic usb_suspend_i,
  input wire logic usb_resume_i,
  output logic remote_wake_o,
  output logic [1:0] power_state_o
);
  import rwd_pkg::*;

  rwd_state_t q;
  rwd_state_t d;
  logic [SYNC_W-1:0] sync_lv;
  logic phy_irq;
  logic [NUM_PINS-1:0] pin_lv;
  logic [NUM_PINS-1:0] pin_hit;
  logic mac_evt;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wclr;
  logic wake_irq;
  logic wake_req;
  logic pin_req;
  logic [31:0] pmc_old;
  logic [31:0] pmc_new;

  // Byte lane mask from the Wishbone select lines.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Write-through of a masked field, keeping unselected lanes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // RQ24: synchronise pins, PHY.
  rwd_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({phy_irq_i, pin_i}),
    .sync_o(sync_lv)
  );

  assign phy_irq = sync_lv[NUM_PINS];
  assign pin_lv = sync_lv[NUM_PINS-1:0];

  rwd_pin_wake u_pin (
    .pin_i(pin_lv),
    .func_i(q.func),
    .low_dir_i(q.low_dir),
    .high_en_i(q.high_en),
    .high_dir_i(q.high_dir),
    .pol_i(q.pin_pol),
    .wen_i(q.pin_wen),
    .hit_o(pin_hit)
  );

  // RQ1: composite MAC wake.
  assign mac_evt = (unicast_hit_i && q.uni_en) ||
                   (magic_hit_i && q.mag_en) ||
                   (frame_hit_i && q.frm_en);

  // RQ2: internal wake interrupt, held by status.
  // RQ25: status plus enable is level.
  assign wake_irq = (q.lan_en && q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_LAN]) ||
                    (q.energy_wake_en && q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_ED]);

  // RQ8: pin requests in any suspend.
  assign pin_req = |(q.pin_sts & q.pin_wen);

  // RQ5: LAN only in state A.
  // RQ6: energy only in state B.
  // RQ21: deepest state ignores both.
  assign wake_req =
    (q.pstate == RWD_SUSP_A && q.lan_en && q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_LAN]) ||
    (q.pstate == RWD_SUSP_B && q.energy_wake_en && q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_ED]) ||
    (q.pstate != RWD_NORMAL && pin_req);

  // A write lands on the edge where ack is already high.
  assign wr = cyc_i && stb_i && we_i && q.ack;
  assign wmask = lane_mask(sel_i);
  assign wclr = dat_i & wmask;
  // Only the writable control fields of the power register take the merge.
  assign pmc_old = {26'h0, q.mode, q.lan_en, q.energy_wake_en, 2'h0};
  assign pmc_new = merge(pmc_old, dat_i, wmask);

  always_comb begin
    d = q;
    d.wake = 1'b0;

    // Bus handshake: one wait cycle, ack for one cycle only.
    d.ack = cyc_i && stb_i && !q.ack;

    // RQ3: status bits set by source.
    // RQ16: clear ignored while asserted.
    d.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_LAN] = mac_evt || q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_LAN];
    // RQ22: energy bit held by PHY.
    d.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_ED] = phy_irq || q.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_ED];
    if (wr && adr_i[7:2] == ADR_PMC[7:2]) begin
      if (wclr[PMC_WAKEUP_STATUS_BITS_LAN] && !mac_evt) begin
        d.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_LAN] = 1'b0;
      end
      if (wclr[PMC_WAKEUP_STATUS_BITS_ED] && !phy_irq) begin
        d.wakeup_status_bits[PMC_WAKEUP_STATUS_BITS_ED] = 1'b0;
      end
    end

    // RQ4: frame source status.
    d.frm_seen = q.frm_seen || (frame_hit_i && q.frm_en);
    d.mag_seen = q.mag_seen || (magic_hit_i && q.mag_en);
    if (wr && adr_i[7:2] == ADR_MWC[7:2]) begin
      if (wclr[MWC_FRM_SEEN] && !(frame_hit_i && q.frm_en)) begin
        d.frm_seen = 1'b0;
      end
      if (wclr[MWC_MAG_SEEN] && !(magic_hit_i && q.mag_en)) begin
        d.mag_seen = 1'b0;
      end
    end

    // RQ12: per-pin status, set wins.
    d.pin_sts = (q.pin_sts & ~((wr && adr_i[7:2] == ADR_IST[7:2]) ?
                 wclr[NUM_PINS-1:0] : 8'h00)) | pin_hit;

    // Plain control writes, honouring byte lanes.
    if (wr) begin
      case (adr_i[7:2])
        ADR_PMC[7:2]: begin
          d.energy_wake_en = pmc_new[PMC_ENERGY_WAKE_EN];
          d.lan_en = pmc_new[PMC_LAN_EN];
          d.mode = pmc_new[PMC_MODE_LSB +: 2];
        end
        ADR_MWC[7:2]: begin
          if (wmask[0]) begin
            d.uni_en = dat_i[MWC_UNI_EN];
            d.mag_en = dat_i[MWC_MAG_EN];
            d.frm_en = dat_i[MWC_FRM_EN];
          end
        end
        ADR_LPC[7:2]: begin
          if (wmask[0]) begin
            d.func = dat_i[5:0];
          end
          if (wmask[LPC_DIR_LSB]) begin
            d.low_dir = dat_i[LPC_DIR_LSB +: NUM_LOW];
          end
        end
        ADR_HPC[7:2]: begin
          if (wmask[0]) begin
            d.high_en = dat_i[NUM_HIGH-1:0];
          end
          if (wmask[HPC_DIR_LSB]) begin
            d.high_dir = dat_i[HPC_DIR_LSB +: NUM_HIGH];
          end
        end
        ADR_PWK[7:2]: begin
          if (wmask[0]) begin
            d.pin_wen = dat_i[NUM_PINS-1:0];
          end
          if (wmask[PWK_POL_LSB]) begin
            d.pin_pol = dat_i[PWK_POL_LSB +: NUM_PINS];
          end
        end
        default: begin
          d.pin_wen = q.pin_wen;
        end
      endcase
    end

    // Power state sequencing.
    case (q.pstate)
      RWD_NORMAL: begin
        if (usb_suspend_i) begin
          // RQ20: mode selects suspend depth.
          case (q.mode)
            MODE_A: d.pstate = RWD_SUSP_A;
            MODE_B: d.pstate = RWD_SUSP_B;
            default: d.pstate = RWD_SUSP_C;
          endcase
        end
      end
      RWD_SUSP_A, RWD_SUSP_B, RWD_SUSP_C: begin
        // RQ14: return to normal on wake.
        // RQ18: frame wake returns normal.
        // RQ7: signal remote wake.
        if (wake_req) begin
          d.pstate = RWD_NORMAL;
          d.wake = 1'b1;
        end else if (usb_resume_i) begin
          d.pstate = RWD_NORMAL;
        end
      end
      default: d.pstate = RWD_NORMAL;
    endcase

    // Read data is captured with the ack so it is stable under it.
    d.rdata = q.rdata;
    if (cyc_i && stb_i && !q.ack) begin
      d.rdata = 32'h0;
      case (adr_i[7:2])
        ADR_PMC[7:2]: begin
          d.rdata[PMC_WAKEUP_STATUS_BITS_LAN:PMC_WAKEUP_STATUS_BITS_ED] = q.wakeup_status_bits;
          d.rdata[PMC_ENERGY_WAKE_EN] = q.energy_wake_en;
          d.rdata[PMC_LAN_EN] = q.lan_en;
          d.rdata[PMC_MODE_LSB +: 2] = q.mode;
          d.rdata[PMC_READY] = (q.pstate == RWD_NORMAL);
          d.rdata[PMC_STATE_LSB +: 2] = q.pstate;
        end
        ADR_MWC[7:2]: begin
          d.rdata[MWC_UNI_EN] = q.uni_en;
          d.rdata[MWC_MAG_EN] = q.mag_en;
          d.rdata[MWC_FRM_EN] = q.frm_en;
          d.rdata[MWC_FRM_SEEN] = q.frm_seen;
          d.rdata[MWC_MAG_SEEN] = q.mag_seen;
        end
        ADR_LPC[7:2]: begin
          d.rdata[5:0] = q.func;
          d.rdata[LPC_DIR_LSB +: NUM_LOW] = q.low_dir;
        end
        ADR_HPC[7:2]: begin
          d.rdata[NUM_HIGH-1:0] = q.high_en;
          d.rdata[HPC_DIR_LSB +: NUM_HIGH] = q.high_dir;
        end
        ADR_PWK[7:2]: begin
          d.rdata[NUM_PINS-1:0] = q.pin_wen;
          d.rdata[PWK_POL_LSB +: NUM_PINS] = q.pin_pol;
        end
        ADR_IST[7:2]: begin
          d.rdata[NUM_PINS-1:0] = q.pin_sts;
        end
        default: begin
          d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= MODE_RST;
      q.pstate <= RWD_NORMAL;
    end else begin
      q <= d;
    end
  end

  // The wake interrupt itself is a level; the USB side sees the exit.
  assign remote_wake_o = q.wake;
  assign power_state_o = q.pstate;
  assign ack_o = q.ack;
  assign dat_o = q.rdata;

  logic unused_irq;
  assign unused_irq = wake_irq;
endmodule

// ===== tb/rwd_top_sva.sv
// Port assertions for the remote wake event detector.
`timescale 1ns/10ps
module rwd_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // USB side
  input wire logic usb_suspend_i,
  input wire logic usb_resume_i,
  input wire logic remote_wake_o,
  input wire logic [1:0] power_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_take;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack late");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_unm;
    ack_o && !we_i && adr_i[7:2] > 6'h05 |-> dat_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_wake_exit;
    remote_wake_o |-> power_state_o == 2'h0 && $past(power_state_o) != 2'h0;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("bad wake");
  property p_entry;
    power_state_o != $past(power_state_o) && power_state_o != 2'h0
      |-> $past(power_state_o) == 2'h0 && $past(usb_suspend_i);
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry");
  property p_resume;
    power_state_o != 2'h0 && usb_resume_i |=> power_state_o == 2'h0;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_hold;
    power_state_o != 2'h0 && !usb_resume_i
      |=> power_state_o == $past(power_state_o) || remote_wake_o;
  endproperty
  a_hold: assert property (p_hold) else $error("silent exit");
  property p_norm;
    power_state_o == 2'h0 && !usb_suspend_i |=> power_state_o == 2'h0;
  endproperty
  a_norm: assert property (p_norm) else $error("stray suspend");
endmodule
bind rwd_top rwd_chk u_rwd_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .usb_suspend_i(usb_suspend_i),
  .usb_resume_i(usb_resume_i), .remote_wake_o(remote_wake_o),
  .power_state_o(power_state_o));

// ===== tb/rwd_host.sv
// Host model: Wishbone master and USB suspend and resume signalling.
`timescale 1ns/10ps
module rwd_host (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] dat_o = 32'h0,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  // USB signalling
  output logic susp_o = 1'b0,
  output logic res_o = 1'b0
);
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data is scrambled so nothing relies on stale values.
    dat_o <= ~d;
  endtask
  task sig(input logic r);
    @(posedge clk_i);
    res_o <= r;
    susp_o <= !r;
    @(posedge clk_i);
    res_o <= 1'b0;
    susp_o <= 1'b0;
    // The new power state is launched on the edge above; let it settle.
    @(posedge clk_i);
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the remote wake event detector.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  import rwd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] hit = 3'h0;
  logic phy = 1'b0;
  logic [7:0] pin = 8'h00;
  logic cyc, stb, we, susp, res, ack, rw;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, q;
  logic [1:0] st;
  int miscompares = 0;
  int checked = 0;
  always #10 clk_i = ~clk_i;
  rwd_top u_rwd_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat),
    .ack_o(ack), .unicast_hit_i(hit[0]), .magic_hit_i(hit[1]),
    .frame_hit_i(hit[2]), .phy_irq_i(phy), .pin_i(pin),
    .usb_suspend_i(susp), .usb_resume_i(res), .remote_wake_o(rw),
    .power_state_o(st));
  rwd_host u_rwd_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wd), .dat_i(rdat), .ack_i(ack),
    .susp_o(susp), .res_o(res));
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    u_rwd_host.xfer(1'b0, a, 32'h0, 4'hF, q);
    `CHK(n, e, q)
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_rwd_host.xfer(1'b1, a, d, 4'hF, q);
  endtask
  task wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    u_rwd_host.xfer(1'b1, a, d, s, q);
  endtask
  task pulse(input logic [2:0] h);
    @(posedge clk_i);
    hit <= h;
    @(posedge clk_i);
    hit <= 3'h0;
  endtask
  task wake(input logic e, input logic [1:0] s, input string n);
    logic w;
    w = 1'b0;
    repeat (12) begin
      @(posedge clk_i);
      if (rw === 1'b1) w = 1'b1;
    end
    `CHK(n, e, w)
    `CHK(n, s, st)
  endtask
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_PMC, 32'h60, "pmc_rst");
    rd(8'h18, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(ADR_MWC, 32'h30 | (32'h1 << i));
      wr(ADR_PMC, 32'h2);
      wr(ADR_PMC, 32'h8);
      u_rwd_host.sig(1'b0);
      `CHK("susp_a", 2'h1, st)
      pulse(3'h1 << i);
      wake(1'b1, 2'h0, "lan_wake");
      rd(ADR_PMC, 32'h4A, "lan_sts");
      rd(ADR_MWC, (32'h1 << i) | (i == 1 ? 32'h20 : i == 2 ? 32'h10 : 32'h0),
         "seen");
    end
    $display("test mac done");
    @(posedge clk_i);
    hit <= 3'h4;
    wr(ADR_PMC, 32'h2);
    rd(ADR_PMC, 32'h42, "lan_held");
    @(posedge clk_i);
    hit <= 3'h0;
    wr(ADR_PMC, 32'h2);
    rd(ADR_PMC, 32'h40, "lan_clr");
    wr(ADR_PMC, 32'h18);
    u_rwd_host.sig(1'b0);
    `CHK("susp_b", 2'h2, st)
    pulse(3'h4);
    wake(1'b0, 2'h2, "lan_in_b");
    u_rwd_host.sig(1'b1);
    `CHK("resume", 2'h0, st)
    wr(ADR_PMC, 32'h2);
    $display("test lan_state done");
    wr(ADR_PMC, 32'h14);
    u_rwd_host.sig(1'b0);
    @(posedge clk_i);
    phy <= 1'b1;
    wake(1'b1, 2'h0, "ed_wake");
    wr(ADR_PMC, 32'h5);
    rd(ADR_PMC, 32'h45, "ed_held");
    @(posedge clk_i);
    phy <= 1'b0;
    wr(ADR_PMC, 32'h5);
    rd(ADR_PMC, 32'h44, "ed_clr");
    $display("test energy done");
    wr(ADR_PMC, 32'h20);
    for (int k = 0; k < 8; k++) begin
      wr(ADR_PWK, 32'h101 << k);
      wr(ADR_IST, 32'hFF);
      u_rwd_host.sig(1'b0);
      `CHK("susp_c", 2'h3, st)
      @(posedge clk_i);
      pin <= 8'h1 << k;
      wake(1'b1, 2'h0, "pin_wake");
      rd(ADR_IST, 32'h1 << k, "pin_sts");
      @(posedge clk_i);
      pin <= 8'h00;
    end
    $display("test pins done");
    wr(ADR_HPC, 32'h1);
    wr(ADR_PWK, 32'h808);
    wr(ADR_IST, 32'hFF);
    u_rwd_host.sig(1'b0);
    @(posedge clk_i);
    pin <= 8'h08;
    wake(1'b0, 2'h3, "pin_output");
    u_rwd_host.sig(1'b1);
    `CHK("pin_resume", 2'h0, st)
    $display("test pin_output done");
    wr(ADR_HPC, 32'h100);
    wr(ADR_IST, 32'hFF);
    u_rwd_host.sig(1'b0);
    wake(1'b0, 2'h3, "pin_dir");
    u_rwd_host.sig(1'b1);
    wr(ADR_HPC, 32'h0);
    wrs(ADR_PWK, 32'h1, 4'h1);
    rd(ADR_PWK, 32'h801, "lanes");
    wr(ADR_LPC, 32'h1);
    wr(ADR_IST, 32'hFF);
    u_rwd_host.sig(1'b0);
    wake(1'b0, 2'h3, "pin_func");
    u_rwd_host.sig(1'b1);
    `CHK("cfg_resume", 2'h0, st)
    wr(ADR_LPC, 32'h0);
    rd(ADR_IST, 32'h1, "pin_low");
    $display("test pin_cfg done");
    end_sim;
  end
endmodule
